// ### hw/rx_framer_cfg.svh
// constants of the receive path framer: offsets, fields, presets, timing
//
// Behaviour
// - swap bit 3 routes input a to auxiliary, input b to main receiver.
// - after reset input a feeds main receiver, input b feeds auxiliary.
// - only the main receiver feeds the decoder; auxiliary only monitors level.
// - level register holds main and auxiliary peak levels of a tag response.
// - filter register bits 7..4 each select one band-pass range.
// - filter register bits 3:2 set gain reduction; bits 1:0 reserved.
// - protocol choice presets the filter register; host may overwrite later.
// - bit decoder yields bits and strobe, tolerating partly corrupted halves.
// - framer builds bytes and drops frame and communication markers.
// - parity and crc are checked and stripped; payload goes to 12-byte fifo.
// - a detected start of frame sets its flag in the interrupt status.
// - end of receive and data present in fifo raise the interrupt line.
// - fifo status register shows the byte count; host reads that many.
// - fifo reaching three quarters (nine bytes) raises an interrupt.
// - framing, parity or crc errors raise interrupt and record their cause.
// - every protocol register write reloads all protocol presets.
// - after transmit, decoders held in reset for wait value times 9.44 us.
// - protocol write presets the receive wait register.
// - no-response timer counts 37.76 us steps from slot start, then flags.
// - protocol write presets the no-response wait register.
// - chip control bit 1 enables the receiver.
`ifndef RX_FRAMER_CFG_SVH
`define RX_FRAMER_CFG_SVH

// register offsets
`define REG_CHIP_CTRL   8'h00
`define REG_PROTOCOL    8'h01
`define REG_NORESP_WAIT 8'h07
`define REG_RX_WAIT     8'h08
`define REG_FILTER_GAIN 8'h0a
`define REG_IRQ_STATUS  8'h0c
`define REG_LEVELS      8'h0f
`define REG_FIFO_STATUS 8'h1c
`define REG_FIFO_DATA   8'h1f

// field positions
`define CHIP_RX_EN_BIT  1
`define CHIP_SWAP_BIT   3
`define PROTO_RATE_BIT  1
`define IRQ_END_RX      7
`define IRQ_SOF         6
`define IRQ_FIFO_HIGH   5
`define IRQ_CRC_ERR     4
`define IRQ_PARITY_ERR  3
`define IRQ_FRAME_ERR   2
`define IRQ_NO_RESP     1
`define IRQ_FIFO_DATA   0

// reset values
`define CHIP_CTRL_RST   8'h00
`define PROTOCOL_RST    8'h02

// presets reloaded on each protocol write, per data rate
`define FILTER_PRESET   8'h40
`define RXWAIT_PRE_HI   8'h1f
`define RXWAIT_PRE_LO   8'h1f
`define NORESP_PRE_HI   8'h0e
`define NORESP_PRE_LO   8'h2f

// fifo and crc
`define FIFO_DEPTH      12
`define FIFO_HIGH_LEVEL 9
`define CRC_PRESET      16'hffff
`define CRC_POLY_REV    16'h8408
`define CRC_RESIDUE     16'hf0b8

// timing
`define CLK_MHZ         25
`define RXWAIT_STEP_NS  9440
`define NORESP_STEP_NS  37760
`define BIT_PERIOD_NS   37760
`define RXWAIT_STEP_CYC (`RXWAIT_STEP_NS * `CLK_MHZ / 1000)
`define NORESP_STEP_CYC (`NORESP_STEP_NS * `CLK_MHZ / 1000)
`define HALF_BIT_CYC    (`BIT_PERIOD_NS * `CLK_MHZ / 2000)

`endif

// ### hw/rx_framer_pkg.sv
// types shared by the receive path framer modules
package rx_framer_pkg;
    typedef enum logic [2:0] {
        DEC_IDLE  = 3'b001,
        DEC_HALF1 = 3'b010,
        DEC_HALF2 = 3'b100
    } dec_state_t;
endpackage : rx_framer_pkg

// ### hw/rx_fifo_mem.sv
// small receive fifo with registered read data
`timescale 1ns/100ps
module rx_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 12
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic                       push,
    input  wire logic [WIDTH-1:0]           pushData,
    input  wire logic                       pop,
    output logic      [WIDTH-1:0]           rdData,
    output logic      [$clog2(DEPTH+1)-1:0] count
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0]           mem [DEPTH];
    logic [PW-1:0]              wrPtr_ff;
    logic [PW-1:0]              rdPtr_ff;
    logic [$clog2(DEPTH+1)-1:0] count_ff;
    logic                       doPush;
    logic                       doPop;

    // full drops pushes, empty ignores pops
    assign doPush = push && (count_ff != ($clog2(DEPTH+1))'(DEPTH));
    assign doPop  = pop && (count_ff != '0);
    assign count  = count_ff;

    // storage has no reset; only pointers matter
    always_ff @(posedge clock)
    begin
        if (doPush)
            mem[wrPtr_ff] <= pushData;
    end

    // read data leaves through a register
    always_ff @(posedge clock)
    begin
        if (rst)
            rdData <= '0;
        else if (doPop)
            rdData <= mem[rdPtr_ff];
    end

    // pointers wrap by hand since the depth need not be a power of two
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (doPush)
                wrPtr_ff <= (wrPtr_ff == LAST) ? '0 : wrPtr_ff + 1'b1;
            if (doPop)
                rdPtr_ff <= (rdPtr_ff == LAST) ? '0 : rdPtr_ff + 1'b1;
            if (doPush && !doPop)
                count_ff <= count_ff + 1'b1;
            else if (doPop && !doPush)
                count_ff <= count_ff - 1'b1;
        end
    end
endmodule : rx_fifo_mem

// ### hw/rx_bit_decoder.sv
// subcarrier bit decoder: majority vote per half bit, markers as both halves
`timescale 1ns/100ps
module rx_bit_decoder
    import rx_framer_pkg::*;
#(
    parameter int HALF = 472
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic hold,
    input  wire logic subcarrier,
    output logic      bitStrobe,
    output logic      bitValue,
    output logic      sofStrobe,
    output logic      eofStrobe,
    output logic      codeErr
);
    localparam int CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);
    localparam logic [CW-1:0] MAJ  = CW'(HALF / 2);

    dec_state_t    state_ff;
    logic [CW-1:0] cyc_ff;
    logic [CW-1:0] ones_ff;
    logic          firstHalf_ff;
    logic          inFrame_ff;
    logic          halfLevel;

    // voting over the whole half tolerates noisy or clipped patterns
    assign halfLevel = (ones_ff + CW'(subcarrier)) > MAJ;

    always_ff @(posedge clock)
    begin
        bitStrobe <= 1'b0;
        sofStrobe <= 1'b0;
        eofStrobe <= 1'b0;
        codeErr   <= 1'b0;
        if (rst || hold)
        begin
            state_ff     <= DEC_IDLE;
            cyc_ff       <= '0;
            ones_ff      <= '0;
            firstHalf_ff <= 1'b0;
            inFrame_ff   <= 1'b0;
            bitValue     <= 1'b0;
        end
        else
        begin
            case (state_ff)
                DEC_IDLE:
                begin
                    cyc_ff  <= '0;
                    ones_ff <= '0;
                    if (subcarrier)
                        state_ff <= DEC_HALF1;
                end
                DEC_HALF1, DEC_HALF2:
                begin
                    cyc_ff  <= cyc_ff + 1'b1;
                    ones_ff <= ones_ff + CW'(subcarrier);
                    if (cyc_ff == LAST)
                    begin
                        cyc_ff  <= '0;
                        ones_ff <= '0;
                        if (state_ff == DEC_HALF1)
                        begin
                            firstHalf_ff <= halfLevel;
                            state_ff     <= DEC_HALF2;
                        end
                        else
                        begin
                            // classify the symbol: 10/01 data, 11 marker
                            state_ff <= DEC_HALF1;
                            if (firstHalf_ff && halfLevel)
                            begin
                                sofStrobe  <= !inFrame_ff;
                                eofStrobe  <= inFrame_ff;
                                inFrame_ff <= !inFrame_ff;
                                if (inFrame_ff)
                                    state_ff <= DEC_IDLE;
                            end
                            else if (firstHalf_ff != halfLevel && inFrame_ff)
                            begin
                                bitStrobe <= 1'b1;
                                bitValue  <= firstHalf_ff;
                            end
                            else
                            begin
                                codeErr    <= inFrame_ff;
                                inFrame_ff <= 1'b0;
                                state_ff   <= DEC_IDLE;
                            end
                        end
                    end
                end
                default:
                    state_ff <= DEC_IDLE;
            endcase
        end
    end
endmodule : rx_bit_decoder

// ### hw/rx_path_framer.sv
// receive path: input routing, filter setup, framing, fifo, timers, status
`timescale 1ns/100ps
`include "rx_framer_cfg.svh"
module rx_path_framer
    import rx_framer_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH,
    parameter int HALF_CYC   = `HALF_BIT_CYC,
    parameter int WAIT_CYC   = `RXWAIT_STEP_CYC,
    parameter int NORESP_CYC = `NORESP_STEP_CYC
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    input  wire logic       rxInputA,
    input  wire logic       rxInputB,
    input  wire logic [2:0] levelMain,
    input  wire logic [2:0] levelAux,
    input  wire logic       txEnd,
    input  wire logic       slotStart,
    output logic            mainFromB,
    output logic            auxMonitor,
    output logic            receiverOn,
    output logic      [3:0] filterBand,
    output logic      [1:0] gainReduction,
    output logic            irq
);
    localparam int CNTW = $clog2(FIFO_DEPTH + 1);

    // pin inputs pass two flip-flops first
    logic [1:0] syncA_ff;
    logic [1:0] syncB_ff;
    logic [2:0] lvlMainS1_ff;
    logic [2:0] lvlMainS2_ff;
    logic [2:0] lvlAuxS1_ff;
    logic [2:0] lvlAuxS2_ff;

    logic [7:0] chipCtrl_ff;
    logic [7:0] protocol_ff;
    logic [7:0] noRespWait_ff;
    logic [7:0] rxWait_ff;
    logic [7:0] filterGain_ff;
    logic [7:0] irqStatus_ff;
    logic [2:0] peakMain_ff;
    logic [2:0] peakAux_ff;
    logic [7:0] rdReg_ff;
    logic       rdFifo_ff;
    logic [7:0] irqSet;
    logic [7:0] irqClr;

    logic       mainSignal;
    logic       decHold;
    logic       bitStrobe;
    logic       bitValue;
    logic       sofStrobe;
    logic       eofStrobe;
    logic       codeErr;

    logic [8:0]  shift_ff;
    logic [3:0]  bitCnt_ff;
    logic [7:0]  hold0_ff;
    logic [7:0]  hold1_ff;
    logic [1:0]  held_ff;
    logic [15:0] crc_ff;
    logic        receiving_ff;
    logic        byteDone;
    logic [7:0]  byteData;
    logic        fifoPush;
    logic        fifoPop;
    logic [7:0]  fifoRdData;
    logic [CNTW-1:0] fifoCount;
    logic [CNTW-1:0] prevCount_ff;

    logic [8:0]  waitPre_ff;
    logic [7:0]  waitCnt_ff;
    logic [9:0]  nrPre_ff;
    logic [7:0]  nrCnt_ff;
    logic        nrActive_ff;
    logic        noRespHit;

    logic wrProto;

    // reflected crc-16 over one byte, lsb first
    function automatic logic [15:0] crcByte(input logic [15:0] c,
                                            input logic [7:0]  d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ `CRC_POLY_REV) : (r >> 1);
        return r;
    endfunction : crcByte

    always_ff @(posedge clock)
    begin
        syncA_ff     <= {syncA_ff[0], rxInputA};
        syncB_ff     <= {syncB_ff[0], rxInputB};
        lvlMainS1_ff <= levelMain;
        lvlMainS2_ff <= lvlMainS1_ff;
        lvlAuxS1_ff  <= levelAux;
        lvlAuxS2_ff  <= lvlAuxS1_ff;
    end

    // input routing; only the main path reaches the decoder
    assign mainFromB  = chipCtrl_ff[`CHIP_SWAP_BIT];
    assign mainSignal = mainFromB ? syncB_ff[1] : syncA_ff[1];
    assign auxMonitor = mainFromB ? syncA_ff[1] : syncB_ff[1];
    assign receiverOn = chipCtrl_ff[`CHIP_RX_EN_BIT];
    assign filterBand    = filterGain_ff[7:4];
    assign gainReduction = filterGain_ff[3:2];

    assign wrProto = regWrite && (regAddr == `REG_PROTOCOL);

    // host registers; a protocol write reloads every preset it owns
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            chipCtrl_ff   <= `CHIP_CTRL_RST;
            protocol_ff   <= `PROTOCOL_RST;
            filterGain_ff <= `FILTER_PRESET;
            rxWait_ff     <= `RXWAIT_PRE_HI;
            noRespWait_ff <= `NORESP_PRE_HI;
        end
        else if (wrProto)
        begin
            protocol_ff   <= regWrData;
            filterGain_ff <= `FILTER_PRESET;
            rxWait_ff     <= regWrData[`PROTO_RATE_BIT] ?
                             `RXWAIT_PRE_HI : `RXWAIT_PRE_LO;
            noRespWait_ff <= regWrData[`PROTO_RATE_BIT] ?
                             `NORESP_PRE_HI : `NORESP_PRE_LO;
        end
        else if (regWrite)
        begin
            case (regAddr)
                `REG_CHIP_CTRL:   chipCtrl_ff   <= regWrData;
                `REG_NORESP_WAIT: noRespWait_ff <= regWrData;
                `REG_RX_WAIT:     rxWait_ff     <= regWrData;
                // reserved low bits stay zero
                `REG_FILTER_GAIN: filterGain_ff <= {regWrData[7:2], 2'b00};
                default:          ;
            endcase
        end
    end

    // read path: one cycle latency, fifo data from the memory's register
    assign fifoPop = regRead && (regAddr == `REG_FIFO_DATA);
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdReg_ff  <= 8'h00;
            rdFifo_ff <= 1'b0;
        end
        else if (regRead)
        begin
            rdFifo_ff <= fifoPop;
            case (regAddr)
                `REG_CHIP_CTRL:   rdReg_ff <= chipCtrl_ff;
                `REG_PROTOCOL:    rdReg_ff <= protocol_ff;
                `REG_NORESP_WAIT: rdReg_ff <= noRespWait_ff;
                `REG_RX_WAIT:     rdReg_ff <= rxWait_ff;
                `REG_FILTER_GAIN: rdReg_ff <= filterGain_ff;
                `REG_IRQ_STATUS:  rdReg_ff <= irqStatus_ff;
                `REG_LEVELS:      rdReg_ff <= {2'b01, peakAux_ff,
                                               peakMain_ff};
                `REG_FIFO_STATUS: rdReg_ff <= 8'(fifoCount);
                default:          rdReg_ff <= 8'h00;
            endcase
        end
    end
    assign regRdData = rdFifo_ff ? fifoRdData : rdReg_ff;

    // peak levels of both receivers, cleared by each transmit
    always_ff @(posedge clock)
    begin
        if (rst || txEnd)
        begin
            peakMain_ff <= 3'h0;
            peakAux_ff  <= 3'h0;
        end
        else if (receiving_ff)
        begin
            if (lvlMainS2_ff > peakMain_ff)
                peakMain_ff <= lvlMainS2_ff;
            if (lvlAuxS2_ff > peakAux_ff)
                peakAux_ff <= lvlAuxS2_ff;
        end
    end

    // receive wait: decoders held after transmit ends
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            waitCnt_ff <= 8'h00;
            waitPre_ff <= 9'h000;
        end
        else if (txEnd)
        begin
            waitCnt_ff <= rxWait_ff;
            waitPre_ff <= 9'h000;
        end
        else if (waitCnt_ff != 8'h00)
        begin
            // step tick from the reference clock
            if (waitPre_ff == 9'(WAIT_CYC - 1))
            begin
                waitPre_ff <= 9'h000;
                waitCnt_ff <= waitCnt_ff - 1'b1;
            end
            else
                waitPre_ff <= waitPre_ff + 1'b1;
        end
    end
    assign decHold = txEnd || (waitCnt_ff != 8'h00) || !receiverOn;

    // no-response timer from slot start until a start of frame
    assign noRespHit = nrActive_ff && (nrCnt_ff == noRespWait_ff);
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            nrActive_ff <= 1'b0;
            nrCnt_ff    <= 8'h00;
            nrPre_ff    <= 10'h000;
        end
        else if (slotStart)
        begin
            nrActive_ff <= 1'b1;
            nrCnt_ff    <= 8'h00;
            nrPre_ff    <= 10'h000;
        end
        else if (sofStrobe || noRespHit)
            nrActive_ff <= 1'b0;
        else if (nrActive_ff)
        begin
            if (nrPre_ff == 10'(NORESP_CYC - 1))
            begin
                nrPre_ff <= 10'h000;
                nrCnt_ff <= nrCnt_ff + 1'b1;
            end
            else
                nrPre_ff <= nrPre_ff + 1'b1;
        end
    end

    rx_bit_decoder #(
        .HALF       (HALF_CYC)
    ) decoder (
        .clock      (clock),
        .rst        (rst),
        .hold       (decHold),
        .subcarrier (mainSignal),
        .bitStrobe  (bitStrobe),
        .bitValue   (bitValue),
        .sofStrobe  (sofStrobe),
        .eofStrobe  (eofStrobe),
        .codeErr    (codeErr)
    );

    // bytes of eight data bits and odd parity, lsb first
    assign byteDone = bitStrobe && (bitCnt_ff == 4'd8);
    assign byteData = shift_ff[8:1];
    // two bytes ride behind so the closing crc never enters the fifo
    assign fifoPush = byteDone && (held_ff == 2'd2);

    always_ff @(posedge clock)
    begin
        if (rst || sofStrobe)
        begin
            // markers only restart framing, nothing is stored for them
            shift_ff     <= 9'h000;
            bitCnt_ff    <= 4'd0;
            held_ff      <= 2'd0;
            crc_ff       <= `CRC_PRESET;
            receiving_ff <= sofStrobe;
            hold0_ff     <= 8'h00;
            hold1_ff     <= 8'h00;
        end
        else if (eofStrobe || codeErr)
            receiving_ff <= 1'b0;
        else if (bitStrobe && receiving_ff)
        begin
            shift_ff  <= {bitValue, shift_ff[8:1]};
            bitCnt_ff <= (bitCnt_ff == 4'd8) ? 4'd0 : bitCnt_ff + 1'b1;
            if (byteDone)
            begin
                crc_ff   <= crcByte(crc_ff, byteData);
                hold0_ff <= byteData;
                hold1_ff <= hold0_ff;
                if (held_ff != 2'd2)
                    held_ff <= held_ff + 1'b1;
            end
        end
    end

    rx_fifo_mem #(
        .WIDTH    (8),
        .DEPTH    (FIFO_DEPTH)
    ) fifo (
        .clock    (clock),
        .rst      (rst),
        .push     (fifoPush && receiving_ff),
        .pushData (hold1_ff),
        .pop      (fifoPop),
        .rdData   (fifoRdData),
        .count    (fifoCount)
    );

    // status events; a set in the cycle of a clearing read wins
    always_comb
    begin
        irqSet = 8'h00;
        irqSet[`IRQ_SOF]        = sofStrobe;
        irqSet[`IRQ_END_RX]     = receiving_ff &&
                                  (eofStrobe || codeErr);
        irqSet[`IRQ_FIFO_DATA]  = fifoCount != '0 &&
                                  prevCount_ff == '0;
        irqSet[`IRQ_FIFO_HIGH]  = fifoCount == CNTW'(`FIFO_HIGH_LEVEL) &&
                                  prevCount_ff != fifoCount;
        irqSet[`IRQ_PARITY_ERR] = byteDone && receiving_ff &&
                                  !(^shift_ff[8:1] ^ bitValue);
        irqSet[`IRQ_FRAME_ERR]  = receiving_ff && (codeErr ||
                                  (eofStrobe && (bitCnt_ff != 4'd0 ||
                                   held_ff != 2'd2)) ||
                                  (fifoPush &&
                                   fifoCount == CNTW'(FIFO_DEPTH)));
        irqSet[`IRQ_CRC_ERR]    = receiving_ff && eofStrobe &&
                                  crc_ff != `CRC_RESIDUE;
        irqSet[`IRQ_NO_RESP]    = noRespHit;
        irqClr = (regRead && regAddr == `REG_IRQ_STATUS) ? 8'hff : 8'h00;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            irqStatus_ff <= 8'h00;
            prevCount_ff <= '0;
        end
        else
        begin
            irqStatus_ff <= (irqStatus_ff & ~irqClr) | irqSet;
            prevCount_ff <= fifoCount;
        end
    end

    // line stays high until software reads the status register
    assign irq = irqStatus_ff != 8'h00;
endmodule : rx_path_framer

// ### tb/rx_path_framer_assertions.sv
// port checker for the receive path framer
`timescale 1ns/100ps
module rx_path_framer_assertions #(
    parameter int FIFO_DEPTH = 12
) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    input wire logic       rxInputA,
    input wire logic       rxInputB,
    input wire logic       mainFromB,
    input wire logic       auxMonitor,
    input wire logic       receiverOn,
    input wire logic [3:0] filterBand,
    input wire logic [1:0] gainReduction,
    input wire logic       irq
);
    // one clock domain; reset aborts every attempt but the reset check
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chip_ctrl_a: assert property (regWrite && regAddr == 8'h00 |=>
        mainFromB == $past(regWrData[3]) && receiverOn == $past(regWrData[1]))
        else $error("chip control bits not applied");
    filter_write_a: assert property (regWrite && regAddr == 8'h0a |=>
        {filterBand, gainReduction} == $past(regWrData[7:2]))
        else $error("filter setting not applied");
    proto_preset_a: assert property (regWrite && regAddr == 8'h01 |=>
        filterBand == 4'h4 && gainReduction == 2'b00)
        else $error("filter preset not reloaded");
    reset_state_a: assert property (disable iff (1'b0) rst |=>
        !mainFromB && !receiverOn && !irq && filterBand == 4'h4)
        else $error("reset state wrong");
    // five quiet samples cover the two-flop sync with three cycles to spare
    aux_swapped_a: assert property ((mainFromB && $stable(rxInputA))[*5]
        |-> auxMonitor == rxInputA) else $error("aux not fed from input a");
    aux_straight_a: assert property ((!mainFromB && $stable(rxInputB))[*5]
        |-> auxMonitor == rxInputB) else $error("aux not fed from input b");
    fifo_count_a: assert property (regRead && regAddr == 8'h1c |=>
        regRdData <= 8'(FIFO_DEPTH)) else $error("fifo count above depth");
    filter_reserved_a: assert property (regRead && regAddr == 8'h0a |=>
        regRdData[1:0] == 2'b00) else $error("reserved filter bits set");
    level_format_a: assert property (regRead && regAddr == 8'h0f |=>
        regRdData[7:6] == 2'b01) else $error("level register format wrong");
endmodule : rx_path_framer_assertions

bind rx_path_framer rx_path_framer_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .rxInputA(rxInputA), .rxInputB(rxInputB), .mainFromB(mainFromB),
    .auxMonitor(auxMonitor), .receiverOn(receiverOn), .irq(irq),
    .filterBand(filterBand), .gainReduction(gainReduction));

// ### tb/host_model.sv
// host side model: strobed register writes and reads
`timescale 1ns/100ps
module host_model (
    input  wire logic       clock,
    input  wire logic [7:0] regRdData,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWrite,
    output logic            regRead
);
    // bus idle from time zero; everything changes at the falling edge
    initial {regAddr, regWrData, regWrite, regRead} = '0;
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        {regAddr, regWrData, regWrite} = {a, v, 1'b1};
        @(negedge clock);
        regWrite = 1'b0;
    endtask : wr
    // read data is registered, so it is taken after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clock);
        {regAddr, regRead} = {a, 1'b1};
        @(negedge clock);
        regRead = 1'b0;
        v = regRdData;
    endtask : rd
endmodule : host_model

// ### tb/test_rx_path_framer.sv
// self-checking bench for the receive path framer
`timescale 1ns/100ps
module test_rx_path_framer;
    logic       clock, rst, regWrite, regRead, rxInputA, rxInputB, txEnd;
    logic       slotStart, mainFromB, auxMonitor, receiverOn, irq;
    logic [7:0] regAddr, regWrData, regRdData, d;
    logic [3:0] filterBand;
    logic [1:0] gainReduction;
    int         errorCnt = 0, checked = 0;
    logic [7:0] ra [7] = '{8'h00, 8'h01, 8'h0a, 8'h08, 8'h07, 8'h1c, 8'h0f};
    logic [7:0] rv [7] = '{8'h00, 8'h02, 8'h40, 8'h1f, 8'h0e, 8'h00, 8'h40};
    rx_path_framer #(.HALF_CYC(8), .WAIT_CYC(8), .NORESP_CYC(8)) uut (
        .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .rxInputA(rxInputA), .rxInputB(rxInputB), .levelMain(3'h5),
        .levelAux(3'h2), .txEnd(txEnd), .slotStart(slotStart),
        .mainFromB(mainFromB), .auxMonitor(auxMonitor), .irq(irq),
        .receiverOn(receiverOn), .filterBand(filterBand),
        .gainReduction(gainReduction));
    host_model host (.clock(clock), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));
    // 25 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d);
        cmp(d, exp);
    endtask : chk
    // one symbol on the main input: two halves of eight cycles
    task automatic sym(input logic h1, input logic h2);
        rxInputB = h1;
        repeat (8) @(negedge clock);
        rxInputB = h2;
        repeat (8) @(negedge clock);
    endtask : sym
    // tag reply with crc; bad spoils the parity of the first byte
    task automatic frame(input int n, input logic bad);
        logic [7:0]  b [$];
        logic [15:0] c = 16'hffff;
        logic        p;
        for (int k = 0; k < n; k++)
            b.push_back(8'h31 + 8'(k));
        foreach (b[k])
            for (int i = 0; i < 8; i++)
                c = (c[0] ^ b[k][i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
        b.push_back(~c[7:0]);
        b.push_back(~c[15:8]);
        sym(1'b1, 1'b1);
        foreach (b[k])
        begin
            for (int i = 0; i < 8; i++)
                sym(b[k][i], !b[k][i]);
            p = ~^b[k] ^ (bad && k == 0);
            sym(p, !p);
        end
        sym(1'b1, 1'b1);
        rxInputB = 1'b0;
    endtask : frame
    // main sequence
    initial
    begin
        {rst, rxInputA, rxInputB, txEnd, slotStart} = 5'b10000;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        foreach (ra[i])
            chk(ra[i], rv[i]);
        host.wr(8'h0a, 8'hab);
        chk(8'h0a, 8'ha8);
        cmp({filterBand, gainReduction, 2'b00}, 8'ha8);
        host.wr(8'h01, 8'h00);
        chk(8'h0a, 8'h40);
        chk(8'h08, 8'h1f);
        chk(8'h07, 8'h2f);
        host.wr(8'h00, 8'h0a);
        rxInputA = 1'b1;
        repeat (8) @(negedge clock);
        cmp({5'h0, mainFromB, receiverOn, auxMonitor}, 8'h07);
        slotStart = 1'b1;
        @(negedge clock);
        slotStart = 1'b0;
        repeat (400) @(negedge clock);
        cmp({7'h0, irq}, 8'h01);
        chk(8'h0c, 8'h02);
        txEnd = 1'b1;
        @(negedge clock);
        txEnd = 1'b0;
        repeat (260) @(negedge clock);
        frame(9, 1'b0);
        repeat (40) @(negedge clock);
        cmp({7'h0, irq}, 8'h01);
        chk(8'h0c, 8'he1);
        cmp({7'h0, irq}, 8'h00);
        chk(8'h1c, 8'h09);
        chk(8'h0f, 8'h55);
        for (int k = 0; k < 9; k++)
            chk(8'h1f, 8'h31 + 8'(k));
        chk(8'h1c, 8'h00);
        frame(1, 1'b1);
        repeat (40) @(negedge clock);
        chk(8'h0c, 8'hc9);
        host.wr(8'h01, 8'h02);
        chk(8'h07, 8'h0e);
        tally_and_finish;
    end
    // the run needs under 6000 cycles, so this only trips on a hang
    initial
    begin
        repeat (20000) @(posedge clock);
        errorCnt++;
        tally_and_finish;
    end
endmodule : test_rx_path_framer
